// ===== two_wire_register_slave.sv
// Two-wire serial slave giving an external master access to five byte registers.
//
// Summary of operation
// - Slave only; master clocks and starts transfers.
// - Bytes shift most significant bit first.
// - Data moves only while clock low.
// - Data pin undriven after power-up.
// - Ignore bus until START is seen.
// - Ignore START during power-up or NV write.
// - STOP ends operation, returns to standby.
// - STOP after NV write starts write cycle.
// - Transmitter releases; receiver acknowledges on ninth clock.
// - Acknowledge ID, address and write data.
// - ID is 00111, straps, then direction.
// - ID low bit one reads, zero writes.
// - Write is ID, address, data, STOP.
// - Early STOP discards the write.
// - Current-address read ends on master no-acknowledge.
// - Random read uses dummy write then restart.
// - Keep sending while master acknowledges.
// - Pointer loads from address, increments per byte.
// - Pointer above 04h returns undefined data.
`timescale 1ns/1ps
module two_wire_register_slave (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Serial bus pins; the data pin is open drain.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Address straps.
  input wire logic addr_strap_hi_in,
  input wire logic addr_strap_lo_in,
  // Register contents for the rest of the device.
  output logic [7:0] reg0_out,
  output logic [7:0] reg1_out,
  output logic [7:0] reg2_out,
  output logic [7:0] reg3_out,
  output logic [7:0] reg4_out,
  // Status.
  output logic busy_out
);
  logic [1:0] rst_sync;
  logic rst_n;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [1:0] strap_hi_sync;
  logic [1:0] strap_lo_sync;
  tw_slave_pkg::tw_state_t state;
  tw_slave_pkg::tw_state_t next_state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [7:0] ptr;
  logic [7:0] wr_addr;
  logic [7:0] regs [tw_slave_pkg::REG_COUNT];
  logic [7:0] tx_byte;
  logic drive_low;
  logic [15:0] guard_cnt;
  logic nv_pending;
  logic wr_done;

  // Byte decode.
  logic [7:0] rx_byte;
  logic id_match;
  logic id_read;
  logic id_read_q;
  logic byte_done;
  logic start_ok;

  // Data level as seen at each clock rise.
  logic [1:0] sda_in_pipe;
  logic sda_in_sync;
  logic sda_sample;
  logic sda_q;

  // Pin drive decisions.
  logic ack_due;
  logic rd_first;
  logic rd_bit;
  logic drive_next;

  // Reset release goes through two flops so that all logic leaves reset together.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'h1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pin sampling and START/STOP detection.
  // Only the edges and the START/STOP events are used; the plain clock level is not needed.
  tw_line_sampler sampler (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .scl_raw_in(scl_in),
    .sda_raw_in(sda_in),
    .scl_out(),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(start_det),
    .stop_out(stop_det)
  );

  // Straps are pins from outside the clock domain, so they are synchronised too.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      strap_hi_sync <= 2'h0;
      strap_lo_sync <= 2'h0;
    end else begin
      strap_hi_sync <= {strap_hi_sync[0], addr_strap_hi_in};
      strap_lo_sync <= {strap_lo_sync[0], addr_strap_lo_in};
    end
  end

  // Identification match and direction decode on the fully shifted byte.
  // The strap copies lag the pins by two clocks, which is harmless as straps are static.
  assign rx_byte = shift;
  assign id_match = (rx_byte[tw_slave_pkg::ID_PREFIX_MSB:tw_slave_pkg::ID_PREFIX_LSB]
                     == tw_slave_pkg::ID_PREFIX)
    && (rx_byte[tw_slave_pkg::ID_STRAP_HI_POS] == strap_hi_sync[1])
    && (rx_byte[tw_slave_pkg::ID_STRAP_LO_POS] == strap_lo_sync[1]);
  assign id_read = (rx_byte[tw_slave_pkg::ID_DIR_POS] == tw_slave_pkg::ID_DIR_READ);
  assign byte_done = scl_fall && (bit_cnt == tw_slave_pkg::BITS_PER_BYTE);
  assign start_ok = start_det && (guard_cnt == 16'h0000);

  // Read data comes from the pointer; locations past the last one are undefined.
  function automatic logic [7:0] reg_read(input logic [7:0] p, input logic [7:0] r0,
      input logic [7:0] r1, input logic [7:0] r2, input logic [7:0] r3, input logic [7:0] r4);
    logic [7:0] v;
    v = tw_slave_pkg::UNDEF_DATA;
    unique case (p)
      8'h00: v = r0;
      8'h01: v = r1;
      8'h02: v = r2;
      8'h03: v = r3;
      8'h04: v = r4;
      default: v = tw_slave_pkg::UNDEF_DATA;
    endcase
    return v;
  endfunction
  assign tx_byte = reg_read(ptr, regs[0], regs[1], regs[2], regs[3], regs[4]);

  // Next-state decode for the byte-level protocol.
  always_comb begin
    next_state = state;
    unique case (state)
      tw_slave_pkg::ST_IDLE: next_state = state;
      tw_slave_pkg::ST_ID: begin
        if (byte_done) begin
          next_state = id_match ? tw_slave_pkg::ST_ID_ACK : tw_slave_pkg::ST_IDLE;
        end
      end
      tw_slave_pkg::ST_ID_ACK: begin
        if (scl_fall) begin
          next_state = tw_slave_pkg::ST_ADDR;
        end
      end
      tw_slave_pkg::ST_ADDR: begin
        if (byte_done) begin
          next_state = tw_slave_pkg::ST_ADDR_ACK;
        end
      end
      tw_slave_pkg::ST_ADDR_ACK: begin
        if (scl_fall) begin
          next_state = tw_slave_pkg::ST_WDATA;
        end
      end
      tw_slave_pkg::ST_WDATA: begin
        if (byte_done) begin
          next_state = tw_slave_pkg::ST_WDATA_ACK;
        end
      end
      tw_slave_pkg::ST_WDATA_ACK: begin
        if (scl_fall) begin
          next_state = tw_slave_pkg::ST_WDATA;
        end
      end
      tw_slave_pkg::ST_READ: begin
        // Master no-acknowledge at the ninth bit ends the read. The counter already
        // reads nine at that rise, since it moved on at the fall after the eighth bit.
        if (scl_rise && bit_cnt == 4'h9 && sda_sample) begin
          next_state = tw_slave_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Sampled data level, taken from a local two-flop path with the same delay as the sampler's clock path.
  // The acknowledge seen at the ninth rise is held until the fall that decides whether
  // the next byte starts, because the pin may move again before that fall is seen.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sda_q <= 1'h1;
    end else if (scl_rise) begin
      sda_q <= sda_in_sync;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sda_in_pipe <= 2'h3;
    end else begin
      sda_in_pipe <= {sda_in_pipe[0], sda_in};
    end
  end
  assign sda_in_sync = sda_in_pipe[1];
  assign sda_sample = sda_in_sync;

  // Main sequencer: state, shift register and bit counter.
  // STOP outranks START, and both outrank the byte flow, so a cut frame always ends cleanly.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= tw_slave_pkg::ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
    end else if (stop_det) begin
      state <= tw_slave_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
    end else if (start_ok) begin
      state <= tw_slave_pkg::ST_ID;
      bit_cnt <= 4'h0;
    end else if (state == tw_slave_pkg::ST_ID_ACK && scl_fall && id_read_q) begin
      state <= tw_slave_pkg::ST_READ;
      bit_cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (scl_rise && bit_cnt < tw_slave_pkg::BITS_PER_BYTE) begin
        shift <= {shift[6:0], sda_sample};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_fall && bit_cnt == tw_slave_pkg::BITS_PER_BYTE) begin
        bit_cnt <= 4'h9;
      end else if (scl_fall && bit_cnt == 4'h9) begin
        bit_cnt <= 4'h0;
      end else if (scl_rise && bit_cnt == 4'h9) begin
        bit_cnt <= 4'h9;
      end
    end
  end

  // Direction bit is held from the identification byte until its acknowledge ends.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      id_read_q <= 1'h0;
    end else if (state == tw_slave_pkg::ST_ID && byte_done) begin
      id_read_q <= id_read;
    end
  end

  // Pointer and pending write address; a write is only committed at its acknowledge.
  // A byte that the master refuses still counts as sent, so a later read continues after it.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ptr <= tw_slave_pkg::PTR_RESET;
      wr_addr <= 8'h00;
    end else if (state == tw_slave_pkg::ST_ADDR && byte_done) begin
      ptr <= rx_byte;
      wr_addr <= rx_byte;
    end else if (state == tw_slave_pkg::ST_READ && byte_done) begin
      // Moving on at the eighth fall lets the next first bit be ready at the ninth fall.
      ptr <= ptr + 8'h01;
    end else if (wr_done) begin
      wr_addr <= wr_addr + 8'h01;
      ptr <= wr_addr + 8'h01;
    end
  end

  // Data byte is stored only once its acknowledge clock has ended.
  // A STOP before that fall leaves the registers untouched, which discards a cut write.
  assign wr_done = (state == tw_slave_pkg::ST_WDATA_ACK) && scl_fall;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < tw_slave_pkg::REG_COUNT; i++) begin
        regs[i] <= tw_slave_pkg::REG_RESET;
      end
    end else if (wr_done && wr_addr <= tw_slave_pkg::REG_LAST) begin
      regs[wr_addr[2:0]] <= shift;
    end
  end

  // Guard timer blocks START during power-up and during a non-volatile write cycle.
  // With no register marked in the non-volatile mask, the write cycle never starts.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      guard_cnt <= 16'(tw_slave_pkg::POWERUP_CYC);
      nv_pending <= 1'h0;
    end else if (stop_det && nv_pending) begin
      guard_cnt <= 16'(tw_slave_pkg::NVWRITE_CYC);
      nv_pending <= 1'h0;
    end else begin
      if (guard_cnt != 16'h0000) begin
        guard_cnt <= guard_cnt - 16'h0001;
      end
      if (wr_done && wr_addr <= tw_slave_pkg::REG_LAST) begin
        nv_pending <= tw_slave_pkg::NV_MASK[wr_addr[2:0]];
      end else if (start_ok) begin
        nv_pending <= 1'h0;
      end
    end
  end

  // Output driver. Decisions are taken at a clock fall or at START/STOP, so the pin is only pulled low while
  // the clock is low. START and STOP always release it, so a stray drive cannot hang the bus.
  // The decision lags the pin fall by the synchroniser, which costs some data setup time.
  // Acknowledge after the eighth bit of a received byte that this slave still accepts.
  assign ack_due = (bit_cnt == tw_slave_pkg::BITS_PER_BYTE)
    && (state == tw_slave_pkg::ST_ADDR || state == tw_slave_pkg::ST_WDATA
        || (state == tw_slave_pkg::ST_ID && id_match));
  // First bit of a byte: after the acknowledge of a read identification byte, or after the
  // master acknowledged the previous byte, by which time the pointer has moved on.
  assign rd_first = !tx_byte[7]
    && ((state == tw_slave_pkg::ST_ID_ACK && id_read_q)
        || (state == tw_slave_pkg::ST_READ && bit_cnt == 4'h9 && !sda_q));
  // Remaining bits follow at each fall, most significant first; after the eighth bit the
  // pin is released so that the master can answer in the ninth clock.
  assign rd_bit = (state == tw_slave_pkg::ST_READ) && (bit_cnt != 4'h0)
    && (bit_cnt < tw_slave_pkg::BITS_PER_BYTE) && !tx_byte[3'(7 - bit_cnt[2:0])];
  assign drive_low = ack_due || rd_first || rd_bit;
  assign drive_next = !stop_det && !start_det && drive_low;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_out <= 1'h0;
    end else if (scl_fall || stop_det || start_det) begin
      sda_oe_out <= drive_next;
    end
  end
  // Open drain: the pin is only ever pulled low, never driven high.
  assign sda_out = 1'h0;

  // Register contents and status.
  assign reg0_out = regs[0];
  assign reg1_out = regs[1];
  assign reg2_out = regs[2];
  assign reg3_out = regs[3];
  assign reg4_out = regs[4];
  assign busy_out = (state != tw_slave_pkg::ST_IDLE) || (guard_cnt != 16'h0000);
endmodule

// ===== tw_slave_pkg.sv
// Package with constants shared by the two-wire register slave.
package tw_slave_pkg;
  // Identification byte: upper five bits fixed, then the two strap levels, then direction.
  localparam logic [4:0] ID_PREFIX = 5'h07;
  localparam int ID_PREFIX_MSB = 7;
  localparam int ID_PREFIX_LSB = 3;
  localparam int ID_STRAP_HI_POS = 2;
  localparam int ID_STRAP_LO_POS = 1;
  localparam int ID_DIR_POS = 0;
  localparam logic ID_DIR_READ = 1'h1;
  // Register file.
  localparam int REG_COUNT = 5;
  localparam logic [7:0] REG_LAST = 8'h04;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] UNDEF_DATA = 8'hff;
  // Bits per byte, and the bit counter value at the fall that opens the acknowledge slot.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Power-up settle time in ns and the derived cycles at 25 MHz (least time, rounded up).
  localparam int POWERUP_NS = 1000;
  localparam int CLK_MHZ = 25;
  localparam int POWERUP_CYC = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  // Non-volatile write cycle time in ns and derived cycles.
  localparam int NVWRITE_NS = 2000;
  localparam int NVWRITE_CYC = (NVWRITE_NS * CLK_MHZ + 999) / 1000;
  // Registers whose writes go to non-volatile storage (bit per register).
  localparam logic [4:0] NV_MASK = 5'h00;
  // Protocol states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_ID, ST_ID_ACK, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WDATA_ACK, ST_READ
  } tw_state_t;
endpackage

// ===== tw_line_sampler.sv
// Two-stage synchroniser and edge finder for the serial clock and data pins.
`timescale 1ns/1ps
module tw_line_sampler (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Raw pin levels.
  input wire logic scl_raw_in,
  input wire logic sda_raw_in,
  // Sampled levels and events.
  output logic scl_out,
  output logic scl_rise_out,
  output logic scl_fall_out,
  output logic start_out,
  output logic stop_out
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;

  // Two flops per pin; only the second stage and its delayed copy feed edge logic.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'h1;
      sda_prev <= 1'h1;
    end else begin
      scl_sync <= {scl_sync[0], scl_raw_in};
      sda_sync <= {sda_sync[0], sda_raw_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // Data moving while the clock is high marks START or STOP.
  assign scl_out = scl_sync[1];
  assign scl_rise_out = scl_sync[1] & ~scl_prev;
  assign scl_fall_out = ~scl_sync[1] & scl_prev;
  assign start_out = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign stop_out = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
endmodule

// ===== two_wire_register_slave_assertions.sv
// Concurrent checks on the ports of the two-wire register slave.
`timescale 1ns/1ps
module two_wire_register_slave_assertions (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Serial bus.
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // Registers and status.
  input wire logic [7:0] reg0_out,
  input wire logic [7:0] reg1_out,
  input wire logic [7:0] reg2_out,
  input wire logic [7:0] reg3_out,
  input wire logic [7:0] reg4_out,
  input wire logic busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // All registers in one vector, so any update is seen at once.
  wire logic [39:0] regs = {reg4_out, reg3_out, reg2_out, reg1_out, reg0_out};

  chk_reset_release: assert property ($rose(arst_n_in) |-> !sda_oe_out)
    else $error("Data pin driven just after reset.");
  chk_guard_busy: assert property ($rose(arst_n_in) |-> ##3 busy_out[*8])
    else $error("Busy not held during the power-up guard.");
  chk_open_drain: assert property (sda_oe_out |-> !sda_out)
    else $error("Data pin driven high.");
  // Four high samples leave room for the synchroniser lag after a fall.
  chk_oe_clock_high: assert property (scl_in[*4] |-> $stable(sda_oe_out))
    else $error("Data pin changed while the clock was high.");
  chk_ack_holds: assert property ($rose(sda_oe_out) |-> sda_oe_out[*4])
    else $error("Low drive released too early.");
  chk_idle_quiet: assert property (!busy_out |-> !sda_oe_out)
    else $error("Data pin driven while idle.");
  chk_regs_in_xfer: assert property ($changed(regs) |-> busy_out)
    else $error("Register changed outside a transfer.");
  chk_stop_idle:
    assert property ($past(scl_in) && scl_in && !$past(sda_oe_out) && $rose(sda_in)
      |-> ##[1:8] !busy_out)
    else $error("Stop did not return the block to standby.");

  // Main scenarios.
  cov_ack: cover property ($rose(sda_oe_out));
  cov_write: cover property ($changed(regs));
  cov_idle: cover property ($fell(busy_out));
endmodule

bind two_wire_register_slave two_wire_register_slave_assertions chk (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .reg0_out(reg0_out), .reg1_out(reg1_out),
  .reg2_out(reg2_out), .reg3_out(reg3_out), .reg4_out(reg4_out), .busy_out(busy_out));

// ===== tw_bus_master.sv
// Behavioural two-wire bus master that clocks and frames every transfer.
`timescale 1ns/1ps
module tw_bus_master (
  // Pacing clock.
  input wire logic clk_in,
  // Resolved data line.
  input wire logic sda_in,
  // Driven lines and observed results.
  output logic scl_out,
  output logic sda_low_out,
  output logic seen_ev_out,
  output logic [7:0] seen_out
);
  // Both lines released at time zero; the clock idles high between frames.
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    seen_ev_out = 1'b0;
    seen_out = 8'h00;
  end
  // Half of a 320 ns serial period; changes land just after a clock edge.
  task automatic half();
    repeat (4) @(posedge clk_in);
    #2;
  endtask
  // Hands one observed item to the bench monitor.
  task automatic report(input logic [7:0] v);
    seen_out = v;
    seen_ev_out = ~seen_ev_out;
  endtask
  // One clock pulse; data was set while low and is sampled late in the high phase.
  task automatic pulse(output logic v);
    half();
    scl_out = 1'b1;
    half();
    v = sda_in;
    scl_out = 1'b0;
  endtask
  // START, also a repeated START when the clock is low.
  task automatic start();
    sda_low_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_low_out = 1'b1;
    half();
    scl_out = 1'b0;
  endtask
  // STOP ends every frame and leaves both lines released.
  task automatic stop();
    sda_low_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_low_out = 1'b0;
    half();
  endtask
  // Sends the top n bits of a byte; a full byte also collects the acknowledge.
  task automatic send(input logic [7:0] b, input int n);
    logic v;
    for (int i = 7; i > 7 - n; i--) begin
      sda_low_out = ~b[i];
      pulse(v);
    end
    if (n == 8) begin
      sda_low_out = 1'b0;
      pulse(v);
      report({7'h00, ~v});
    end
  endtask
  // Receives a byte, then acknowledges it or not.
  task automatic recv(input logic mack);
    logic [7:0] d;
    logic v;
    sda_low_out = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(v);
      d[i] = v;
    end
    sda_low_out = mack;
    pulse(v);
    report(d);
  endtask
endmodule

// ===== test_two_wire_register_slave.sv
// Self-checking bench for the two-wire register slave.
`timescale 1ns/1ps
module test_two_wire_register_slave;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic strap_hi = 1'b0;
  logic strap_lo = 1'b0;
  logic scl, m_low, sda_out, sda_oe, busy, ev;
  logic [7:0] seen;
  logic [7:0] shadow [5] = '{default: 8'h00};
  logic [7:0] exp_q [$];
  wire logic [4:0][7:0] regs;
  int mismatches = 0;
  int checks = 0;
  int seed = 16;
  // Open-drain data line with a pull-up.
  wire logic sda_wire = ~(m_low | (sda_oe & ~sda_out));

  always #20 clk_in = ~clk_in;

  two_wire_register_slave dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_out(sda_oe),
    .addr_strap_hi_in(strap_hi), .addr_strap_lo_in(strap_lo), .reg0_out(regs[0]),
    .reg1_out(regs[1]), .reg2_out(regs[2]), .reg3_out(regs[3]), .reg4_out(regs[4]),
    .busy_out(busy));
  tw_bus_master m (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl),
    .sda_low_out(m_low), .seen_ev_out(ev), .seen_out(seen));

  // Compares one value and counts the result.
  task automatic check_val(input string name, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Each item the master sees is matched against the oldest note.
  always @(ev) begin
    if ($time > 0) check_val("bus item", exp_q.pop_front(), seen);
  end
  // Bus helpers: note the expected answer first, then run the transfer.
  function automatic logic [7:0] id(input logic rd);
    return {5'h07, strap_hi, strap_lo, rd};
  endfunction
  function automatic logic [7:0] rdval(input int p);
    return (p <= 4) ? shadow[p] : 8'hff;
  endfunction
  task automatic put(input logic [7:0] b, input logic ack);
    exp_q.push_back({7'h00, ack});
    m.send(b, 8);
  endtask
  task automatic get(input logic [7:0] e, input logic mack);
    exp_q.push_back(e);
    m.recv(mack);
  endtask
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    m.start();
    put(id(1'b0), 1'b1);
    put({5'h00, a}, 1'b1);
    put(d, 1'b1);
    m.stop();
    shadow[a] = d;
    check_val("register", d, regs[a]);
  endtask

  // Watchdog well beyond the expected run of about 2900 cycles.
  initial begin
    #2000000;
    mismatches++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge clk_in);
    #2 arst_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #2;
    check_val("data enable", 8'h00, {7'h00, sda_oe});
    check_val("busy", 8'h01, {7'h00, busy});
    m.start();
    put(id(1'b0), 1'b0);
    m.stop();
    // Every strap setting, then an identification byte with one strap bit wrong.
    for (int s = 0; s < 5; s++) begin
      {strap_hi, strap_lo} = s[1:0];
      write_reg(s[2:0], 8'($random(seed)));
      m.start();
      put(id(1'b0) ^ (s[0] ? 8'h04 : 8'h02), 1'b0);
      m.stop();
    end
    // Stop after the address only, and stop in the middle of a data byte.
    m.start();
    put(id(1'b0), 1'b1);
    put(8'h02, 1'b1);
    m.stop();
    m.start();
    put(id(1'b0), 1'b1);
    put(8'h01, 1'b1);
    m.send(~shadow[1], 4);
    m.stop();
    check_val("register", shadow[2], regs[2]);
    check_val("register", shadow[1], regs[1]);
    // Random read of two bytes, then a current-address read past the last register.
    m.start();
    put(id(1'b0), 1'b1);
    put(8'h00, 1'b1);
    m.start();
    put(id(1'b1), 1'b1);
    for (int p = 0; p < 2; p++) get(rdval(p), p == 0);
    m.stop();
    m.start();
    put(id(1'b1), 1'b1);
    for (int p = 2; p < 6; p++) get(rdval(p), p < 5);
    m.stop();
    check_val("pending notes", 8'h00, 8'(exp_q.size()));
    tally_and_finish();
  end
endmodule
